// *** hdl/laic_integration_timing.sv ***
`timescale 1ns/1ps
module laic_integration_timing (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Register port from the serial slave
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData,
	output logic            regRdValid,
	// Sync strobe written by the host
	input  wire logic       syncPulse,
	// Analog side pins
	input  wire logic       oscIn,
	input  wire logic       chargeIn,
	// Status and mux control
	output logic            oscHalfRate,
	output logic            diodeTwoSel,
	output logic            integrating,
	output logic            resultStrobe,
	output logic      [15:0] sensorData,
	output logic      [15:0] cycleCount
);

	typedef struct packed {
		laic_pkg::laic_state_e state;
		logic [7:0]            cmd;
		logic [7:0]            ctl;
		logic [16:0]           cycCnt;
		logic [16:0]           accum;
		logic [16:0]           d1Save;
		logic [15:0]           dataOut;
		logic [15:0]           timer;
		logic [7:0]            rdData;
		logic                  rdValid;
		logic                  result;
		logic                  diodeTwo;
		logic                  running;
		logic                  oscHalf;
		logic                  chg1;
		logic                  chg2;
	} laic_state_s;

	laic_state_s st_r;
	laic_state_s st_nxt;
	logic        tick;

	// Oscillator edge ticks, rate set by the range bits
	laic_osc_tick u_tick (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.oscIn    (oscIn),
		.halfRate (st_r.oscHalf),
		.tick     (tick)
	);

	// Decoded command and control fields
	logic        extMode;
	logic [1:0]  diodeSel;
	logic [1:0]  rangeSel;
	logic [16:0] target;
	logic        isNop;
	assign extMode  = st_r.cmd[laic_pkg::CMD_TIMING_BIT];
	assign diodeSel = st_r.cmd[laic_pkg::CMD_DIODE_HI:laic_pkg::CMD_DIODE_LO];
	assign rangeSel = st_r.ctl[laic_pkg::CTL_RANGE_HI:laic_pkg::CTL_RANGE_LO];
	assign target   = laic_pkg::laic_cycles(
		st_r.cmd[laic_pkg::CMD_WIDTH_HI:laic_pkg::CMD_WIDTH_LO]);
	assign isNop    = (diodeSel == laic_pkg::DIODE_NOP);

	// Next state of the whole block
	always_comb begin
		logic [16:0] cntNext;
		logic [16:0] accNext;
		logic [16:0] diff;
		logic        finish;
		cntNext = '0;
		accNext = '0;
		diff    = '0;
		finish  = 1'b0;
		st_nxt         = st_r;
		st_nxt.rdValid = 1'b0;
		st_nxt.result  = 1'b0;
		// Charge bit comes from the analog side, two flops first
		st_nxt.chg1    = chargeIn;
		st_nxt.chg2    = st_r.chg1;
		// Range only retunes the oscillator, so it may change any time
		st_nxt.oscHalf = (rangeSel < laic_pkg::RANGE_THREE);

		// Tick and charge accumulation; counter saturates rather than wraps
		cntNext = st_r.cycCnt;
		if (tick && st_r.cycCnt != laic_pkg::CNT_MAX) begin
			cntNext = st_r.cycCnt + 17'h00001;
		end
		accNext = st_r.accum + {16'h0000, tick && st_r.chg2};

		// Conversion engine
		case (st_r.state)
			laic_pkg::ST_IDLE: begin
				if (!isNop && (!extMode || syncPulse)) begin
					st_nxt.state    = laic_pkg::ST_RUN1;
					st_nxt.diodeTwo = (diodeSel == laic_pkg::DIODE_TWO_ONLY);
					st_nxt.cycCnt   = '0;
					st_nxt.accum    = '0;
				end
			end
			laic_pkg::ST_RUN1, laic_pkg::ST_RUN2: begin
				st_nxt.cycCnt = cntNext;
				st_nxt.accum  = accNext;
				if (extMode) begin
					finish = syncPulse;
				end else begin
					finish = tick && (st_r.cycCnt == target - 17'h00001);
				end
				if (finish) begin
					st_nxt.cycCnt = '0;
					st_nxt.accum  = '0;
					if (st_r.state == laic_pkg::ST_RUN1 &&
						diodeSel == laic_pkg::DIODE_DIFFERENCE_SEQUENCE) begin
						st_nxt.d1Save   = accNext;
						st_nxt.state    = laic_pkg::ST_RUN2;
						st_nxt.diodeTwo = 1'b1;
					end else begin
						diff = st_r.d1Save - accNext;
						if (st_r.state == laic_pkg::ST_RUN2) begin
							st_nxt.dataOut = diff[15:0];
						end else begin
							st_nxt.dataOut = accNext[15:0];
						end
						st_nxt.timer    = cntNext[15:0];
						st_nxt.result   = 1'b1;
						st_nxt.state    = laic_pkg::ST_RUN1;
						st_nxt.diodeTwo = (diodeSel == laic_pkg::DIODE_TWO_ONLY);
					end
				end
			end
			default: begin
				st_nxt.state = laic_pkg::ST_IDLE;
			end
		endcase

		// Register writes; a new command restarts conversion cleanly
		if (regWrEn) begin
			if (regAddr == laic_pkg::ADDR_CONV_COMMAND) begin
				st_nxt.cmd      = regWrData;
				st_nxt.state    = laic_pkg::ST_IDLE;
				st_nxt.cycCnt   = '0;
				st_nxt.accum    = '0;
				st_nxt.diodeTwo = 1'b0;
				st_nxt.result   = 1'b0;
			end else if (regAddr == laic_pkg::ADDR_CONTROL) begin
				st_nxt.ctl = regWrData;
			end
		end

		// Register reads, answered one cycle later
		if (regRdEn) begin
			st_nxt.rdValid = 1'b1;
			if (regAddr == laic_pkg::ADDR_CONV_COMMAND) begin
				st_nxt.rdData = st_r.cmd;
			end else if (regAddr == laic_pkg::ADDR_CONTROL) begin
				st_nxt.rdData = st_r.ctl;
			end else if (regAddr == laic_pkg::ADDR_DATA_LO) begin
				st_nxt.rdData = st_r.dataOut[7:0];
			end else if (regAddr == laic_pkg::ADDR_DATA_HI) begin
				st_nxt.rdData = st_r.dataOut[15:8];
			end else if (regAddr == laic_pkg::ADDR_TIMER_LO) begin
				st_nxt.rdData = extMode ? st_r.timer[7:0] : 8'h00;
			end else if (regAddr == laic_pkg::ADDR_TIMER_HI) begin
				st_nxt.rdData = extMode ? st_r.timer[15:8] : 8'h00;
			end else begin
				st_nxt.rdData = 8'h00;
			end
		end

		st_nxt.running = (st_nxt.state != laic_pkg::ST_IDLE);
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r       <= '0;
			st_r.state <= laic_pkg::ST_IDLE;
			st_r.cmd   <= laic_pkg::CMD_RESET;
			st_r.ctl   <= laic_pkg::CTL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign regRdData    = st_r.rdData;
	assign regRdValid   = st_r.rdValid;
	assign oscHalfRate  = st_r.oscHalf;
	assign diodeTwoSel  = st_r.diodeTwo;
	assign integrating  = st_r.running;
	assign resultStrobe = st_r.result;
	assign sensorData   = st_r.dataOut;
	assign cycleCount   = st_r.timer;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Quiet cycle: no register write in flight
	sequence seqQuiet;
		!regWrEn;
	endsequence

	// External strobe while running, no register write
	sequence seqExtStrobe;
		extMode && st_r.running && syncPulse && !regWrEn;
	endsequence

	// Internal conversion reaches its last tick
	sequence seqIntLast;
		!extMode && st_r.running && tick && !regWrEn &&
			st_r.cycCnt == target - 17'h00001;
	endsequence

	property pHalfRate;
		seqQuiet ##1 1'b1 |-> oscHalfRate == ($past(rangeSel) < laic_pkg::RANGE_THREE);
	endproperty

	chk_osc_half_rate: assert property (pHalfRate)
		else $error("oscillator rate does not follow range");

	chk_int_count_end: assert property (seqIntLast |=> st_r.cycCnt == 17'h00000 &&
		st_r.running)
		else $error("internal conversion did not end at 2^n ticks");

	chk_int_no_early: assert property (!extMode && st_r.running && !regWrEn &&
		st_r.cycCnt < target - 17'h00001 |=> !resultStrobe)
		else $error("internal conversion ended early");

	chk_ext_first_start: assert property (extMode && !st_r.running && !isNop &&
		syncPulse && !regWrEn |=> integrating && !resultStrobe &&
		st_r.cycCnt == 17'h00000)
		else $error("first external strobe mishandled");

	chk_ext_restart: assert property (seqExtStrobe |=> integrating &&
		st_r.cycCnt == 17'h00000)
		else $error("strobe did not restart integration");

	chk_ext_timer: assert property (seqExtStrobe ##0
		(diodeSel != laic_pkg::DIODE_DIFFERENCE_SEQUENCE) |=>
		resultStrobe && cycleCount == $past(st_r.cycCnt[15:0]) +
		{15'h0000, $past(tick)})
		else $error("cycle count not reported at strobe");

	chk_diode_difference_sequence_switch: assert property (seqExtStrobe ##0
		(diodeSel == laic_pkg::DIODE_DIFFERENCE_SEQUENCE) ##0
		(st_r.state == laic_pkg::ST_RUN1) |=> diodeTwoSel && !resultStrobe)
		else $error("difference sequence did not switch diode");

	chk_cnt_bound: assert property (st_r.cycCnt <= laic_pkg::CNT_MAX)
		else $error("cycle counter beyond limit");

	chk_nop_idle: assert property (isNop ##1 seqQuiet |-> !integrating)
		else $error("no-op select still integrating");

	chk_timer_hidden: assert property (regRdEn && !extMode &&
		regAddr == laic_pkg::ADDR_TIMER_LO |=> regRdValid && regRdData == 8'h00)
		else $error("timer visible in internal mode");

endmodule

// *** hdl/laic_osc_tick.sv ***
`timescale 1ns/1ps
module laic_osc_tick (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Oscillator pin and rate select
	input  wire logic oscIn,
	input  wire logic halfRate,
	// One-cycle tick per effective oscillator cycle
	output logic      tick
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic phase;
		logic tick;
	} laic_tick_s;

	laic_tick_s st_r;
	laic_tick_s st_nxt;

	// Synchronise, find rising edges, divide by two when slow
	always_comb begin
		st_nxt       = st_r;
		st_nxt.sync1 = oscIn;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev  = st_r.sync2;
		st_nxt.tick  = 1'b0;
		if (st_r.sync2 && !st_r.prev) begin
			st_nxt.phase = !st_r.phase;
			st_nxt.tick  = !halfRate || st_r.phase;
		end
	end

	// Same divider in every timing mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;

endmodule

// *** pkg/laic_pkg.sv ***
// Overview of operation
// - Internal mode ends after exactly 2^n ticks
// - Command bit 5 picks internal or external
// - Command bits 1:0 give the resolution n
// - Ranges 1 and 2 halve the oscillator rate
// - Oscillator behaves alike in both timing modes
// - Single diode: one strobe per conversion after the first
// - Each strobe after the first ends and restarts integration
// - Difference mode: strobes step diode one, two
// - External cycle counter holds at most 65,536
// - External result reports accumulated cycle count
// - Output counts scale linearly, full span / 2^n
// - Range picks one of four span constants; the code only halves the oscillator rate for ranges 1 and 2
// - Width codes give 65,536/4,096/256/16 cycles
// - Diode select: one, two, difference, no-op
// - Control bits 3:2 select range 1 to 4
// - Cycle count readable only in external mode
package laic_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_CONV_COMMAND = 8'h00;
	localparam logic [7:0] ADDR_CONTROL      = 8'h01;
	localparam logic [7:0] ADDR_DATA_LO      = 8'h04;
	localparam logic [7:0] ADDR_DATA_HI      = 8'h05;
	localparam logic [7:0] ADDR_TIMER_LO     = 8'h06;
	localparam logic [7:0] ADDR_TIMER_HI     = 8'h07;

	// Field positions
	localparam int CMD_TIMING_BIT = 5;
	localparam int CMD_DIODE_HI   = 3;
	localparam int CMD_DIODE_LO   = 2;
	localparam int CMD_WIDTH_HI   = 1;
	localparam int CMD_WIDTH_LO   = 0;
	localparam int CTL_RANGE_HI   = 3;
	localparam int CTL_RANGE_LO   = 2;

	// Reset values
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// Diode select codes
	localparam logic [1:0] DIODE_ONE_ONLY            = 2'h0;
	localparam logic [1:0] DIODE_TWO_ONLY            = 2'h1;
	localparam logic [1:0] DIODE_DIFFERENCE_SEQUENCE = 2'h2;
	localparam logic [1:0] DIODE_NOP                 = 2'h3;

	// Range codes; the two lowest run the oscillator at half rate
	localparam logic [1:0] RANGE_THREE = 2'h2;

	// Cycle counts per width code
	localparam logic [16:0] CYC_W0  = 17'h10000;
	localparam logic [16:0] CYC_W1  = 17'h01000;
	localparam logic [16:0] CYC_W2  = 17'h00100;
	localparam logic [16:0] CYC_W3  = 17'h00010;
	localparam logic [16:0] CNT_MAX = 17'h10000;

	// Integration states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN1 = 3'h2,
		ST_RUN2 = 3'h4
	} laic_state_e;

	// Width code to cycle count
	function automatic logic [16:0] laic_cycles(input logic [1:0] code);
		logic [16:0] c;
		c = CYC_W0;
		case (code)
			2'h1: c = CYC_W1;
			2'h2: c = CYC_W2;
			2'h3: c = CYC_W3;
			default: c = CYC_W0;
		endcase
		return c;
	endfunction

endpackage

// *** tb/laic_osc_model.sv ***
`timescale 1ns/1ps
module laic_osc_model (
	// Bench clock
	input  wire logic clk_sys,
	// Oscillator pin toward the device
	output logic      oscIn
);
	logic [2:0] phase;

	// Free running 32 ns square wave; tied to the clock so tick counts are exact
	initial begin
		phase = 3'h0;
		oscIn = 1'b0;
	end
	always @(posedge clk_sys) begin
		phase <= phase + 3'h1;
		oscIn <= (phase < 3'h4);
	end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	// Design ports
	logic        clk_sys;
	logic        rst_n;
	logic        regWrEn;
	logic        regRdEn;
	logic [7:0]  regAddr;
	logic [7:0]  regWrData;
	logic [7:0]  regRdData;
	logic        regRdValid;
	logic        syncPulse;
	logic        oscIn;
	logic        chargeIn;
	logic        oscHalfRate;
	logic        diodeTwoSel;
	logic        integrating;
	logic        resultStrobe;
	logic [15:0] sensorData;
	logic [15:0] cycleCount;
	// Bookkeeping
	int          errors = 0;
	int          nCompared = 0;
	int          cyc = 0;
	int          nRes = 0;
	int          tLast = 0;
	int          tPrev = 0;
	int          base;

	// 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	laic_integration_timing uut (.clk_sys(clk_sys), .rst_n(rst_n), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .syncPulse(syncPulse), .oscIn(oscIn), .chargeIn(chargeIn),
		.oscHalfRate(oscHalfRate), .diodeTwoSel(diodeTwoSel), .integrating(integrating),
		.resultStrobe(resultStrobe), .sensorData(sensorData), .cycleCount(cycleCount));

	laic_osc_model osc (.clk_sys(clk_sys), .oscIn(oscIn));

	// Result strobe times and the hang limit
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (resultStrobe === 1'b1) begin
			nRes  <= nRes + 1;
			tPrev <= tLast;
			tLast <= cyc;
		end
		if (cyc == 20000) begin
			errors = errors + 1;
			endOfTest();
		end
	end

	task automatic endOfTest();
		$display("compared %0d mismatches %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkOut(input logic [15:0] got, input logic [15:0] exp);
		nCompared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWrEn   <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrEn <= 1'b0;
	endtask

	// Answer lands on the same edge that takes the strobe, one edge after it is raised
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		#1;
		chkOut({15'h0000, regRdValid}, 16'h0001);
		chkReg(regRdData, exp);
	endtask

	task automatic syncStrobe();
		@(posedge clk_sys);
		syncPulse <= 1'b1;
		@(posedge clk_sys);
		syncPulse <= 1'b0;
	endtask

	task automatic gap(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Bounded wait for k more results
	task automatic waitRes(input int k);
		int b;
		b = nRes;
		for (int i = 0; i < 4000 && nRes < b + k; i++) @(posedge clk_sys);
		#1;
	endtask

	initial begin
		rst_n     = 1'b0;
		regWrEn   = 1'b0;
		regRdEn   = 1'b0;
		regAddr   = 8'h00;
		regWrData = 8'h00;
		syncPulse = 1'b0;
		chargeIn  = 1'b1;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Reset contents, a write to an unmapped place, and unmapped reads
		rdChk(laic_pkg::ADDR_CONV_COMMAND, laic_pkg::CMD_RESET);
		rdChk(laic_pkg::ADDR_CONTROL, laic_pkg::CTL_RESET);
		wrReg(8'h02, 8'hFF);
		rdChk(8'h02, 8'h00);
		rdChk(8'h3C, 8'h00);
		// Internal timing, 16 ticks, range 4 then range 1
		wrReg(laic_pkg::ADDR_CONTROL, 8'h0C);
		wrReg(laic_pkg::ADDR_CONV_COMMAND, 8'h03);
		rdChk(laic_pkg::ADDR_CONV_COMMAND, 8'h03);
		waitRes(3);
		chkOut({15'h0000, oscHalfRate}, 16'h0000);
		chkOut(16'(tLast - tPrev), 16'h0080);
		chkOut(sensorData, 16'h0010);
		rdChk(laic_pkg::ADDR_DATA_LO, 8'h10);
		rdChk(laic_pkg::ADDR_DATA_HI, 8'h00);
		rdChk(laic_pkg::ADDR_TIMER_LO, 8'h00);
		wrReg(laic_pkg::ADDR_CONTROL, 8'h00);
		waitRes(3);
		chkOut({15'h0000, oscHalfRate}, 16'h0001);
		chkOut(16'(tLast - tPrev), 16'h0100);
		// External timing, single diode, 160 cycles between strobes
		for (int r = 0; r < 2; r++) begin
			wrReg(laic_pkg::ADDR_CONTROL, (r == 0) ? 8'h0C : 8'h00);
			wrReg(laic_pkg::ADDR_CONV_COMMAND, 8'h23);
			// Dark second pass, so data must follow charge and not ticks alone
			chargeIn <= (r == 0);
			syncStrobe();
			// Taken after the strobe so a late internal result is already counted
			base = nRes;
			gap(4);
			chkOut({15'h0000, integrating}, 16'h0001);
			chkOut(16'(nRes - base), 16'h0000);
			gap(154);
			syncStrobe();
			gap(4);
			chkOut(16'(nRes - base), 16'h0001);
			chkOut({15'h0000, integrating}, 16'h0001);
			chkOut(cycleCount, (r == 0) ? 16'h0014 : 16'h000A);
			chkOut(sensorData, (r == 0) ? 16'h0014 : 16'h0000);
			rdChk(laic_pkg::ADDR_TIMER_LO, (r == 0) ? 8'h14 : 8'h0A);
			rdChk(laic_pkg::ADDR_TIMER_HI, 8'h00);
		end
		// Difference sequence: 20 ticks on diode one, 10 on diode two
		wrReg(laic_pkg::ADDR_CONTROL, 8'h0C);
		// Charge back on, settled through the two input flops before the first strobe
		chargeIn <= 1'b1;
		wrReg(laic_pkg::ADDR_CONV_COMMAND, 8'h2B);
		base = nRes;
		syncStrobe();
		gap(158);
		syncStrobe();
		gap(4);
		chkOut({15'h0000, diodeTwoSel}, 16'h0001);
		chkOut(16'(nRes - base), 16'h0000);
		gap(74);
		syncStrobe();
		gap(4);
		chkOut(16'(nRes - base), 16'h0001);
		chkOut({15'h0000, diodeTwoSel}, 16'h0000);
		chkOut(sensorData, 16'h000A);
		chkOut(cycleCount, 16'h000A);
		// No-operation select ignores the strobe
		wrReg(laic_pkg::ADDR_CONV_COMMAND, 8'h2F);
		syncStrobe();
		gap(4);
		chkOut({15'h0000, integrating}, 16'h0000);
		endOfTest();
	end
endmodule
